// ==== src/lums_top.sv ====
// lums_top: per-port line unit maintenance, status and event bank, apb slave
// assumes: line monitor inputs are asynchronous levels; one apb master
`timescale 1ns/1ps
`default_nettype none
module lums_top
  import lums_pkg::*;
#(
  parameter int               PORTS                = LUMS_PORTS,
  // gain limit code, plain default
  parameter logic [LEVEL_W-1:0] EQUALIZER_GAIN_LIMIT = 4'hc
)(
  // clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  // apb slave
  input  wire logic                    psel_in,
  input  wire logic                    penable_in,
  input  wire logic                    pwrite_in,
  input  wire logic [ADDR_W-1:0]       paddr_in,
  input  wire logic [DATA_W-1:0]       pwdata_in,
  input  wire logic [3:0]              pstrb_in,
  output logic      [DATA_W-1:0]       prdata_out,
  output logic                         pready_out,
  output logic                         pslverr_out,
  // line monitor conditions, one bit per port, plus one receive level code per port
  input  wire logic [PORTS-1:0]        signal_loss_in,
  input  wire logic [PORTS-1:0]        transmit_short_in,
  input  wire logic [PORTS-1:0]        transmit_open_in,
  input  wire logic [PORTS-1:0]        attenuator_trip_in,
  input  wire logic [PORTS-1:0]        receive_short_in,
  input  wire logic [PORTS-1:0]        under_equalized_in,
  input  wire logic [PORTS-1:0]        over_equalized_in,
  input  wire logic [PORTS*LEVEL_W-1:0] receive_level_code_in,
  // line mode and pins, one per port
  input  wire logic [PORTS*3-1:0]      pulse_shape_setting_in,
  input  wire logic [PORTS-1:0]        t1_mode_in,
  input  wire logic [PORTS-1:0]        short_haul_in,
  input  wire logic [PORTS-1:0]        transmit_enable_pin_in,
  // line unit controls, one per port
  output logic      [PORTS-1:0]        alarm_send_out,
  output logic      [PORTS-1:0]        loop_remote2_out,
  output logic      [PORTS-1:0]        loop_analog_out,
  output logic      [PORTS-1:0]        loop_remote1_out,
  output logic      [PORTS-1:0]        loop_local_out,
  output logic      [PORTS-1:0]        transmit_power_down_out,
  output logic      [PORTS-1:0]        receive_power_down_out,
  output logic      [PORTS-1:0]        transmit_hiz_out,
  output logic      [PORTS-1:0]        receive_termination_on_out,
  output logic [PORTS*IMP_CODE_W-1:0]  receive_impedance_code_out,
  // interrupt request
  output logic                         line_irq_out
);

  localparam int PI_W = $clog2(PORTS);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [REG_W-1:0]    maint_r  [PORTS];
  logic [REG_W-1:0]    mask_r   [PORTS];
  logic [REG_W-1:0]    imp_r    [PORTS];
  logic [REG_W-1:0]    rt_r     [PORTS];
  logic [REG_W-1:0]    level_r  [PORTS];
  logic [REG_W-1:0]    flags    [PORTS];
  logic [REG_W-1:0]    clear    [PORTS];
  logic [SY_W-1:0]     raw      [PORTS];
  logic [SY_W-1:0]     sy_a_r   [PORTS];
  logic [SY_W-1:0]     sy_b_r   [PORTS];
  logic [PORTS-1:0]    csu_mode;
  logic [PORTS-1:0]    irq_hit;

  // apb state
  logic                pready_r;
  logic                pslverr_r;
  logic [DATA_W-1:0]   prdata_r;
  logic                acc_ok_r;
  logic [PI_W-1:0]     acc_port_r;
  logic [IDX_W-1:0]    acc_sub_r;
  logic                setup;
  logic                wr_en;
  logic                dec_hit;
  logic [PI_W-1:0]     dec_port;
  logic [IDX_W-1:0]    dec_sub;
  logic [IDX_W-1:0]    rel_idx;
  logic [REG_W-1:0]    rd_nxt;

  // control outputs
  logic [PORTS-1:0]    alarm_r;
  logic [PORTS-1:0]    lb_rem2_r;
  logic [PORTS-1:0]    lb_ana_r;
  logic [PORTS-1:0]    lb_rem1_r;
  logic [PORTS-1:0]    lb_loc_r;
  logic [PORTS-1:0]    tx_pd_r;
  logic [PORTS-1:0]    rx_pd_r;
  logic [PORTS-1:0]    tx_hiz_r;
  logic [PORTS-1:0]    term_on_r;
  logic [PORTS*IMP_CODE_W-1:0] imp_code_r;
  logic                irq_r;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // index relative to port 1, folded back onto the port 1 map
  function automatic logic [IDX_W-1:0] rel_index(input logic [ADDR_W-1:0] a);
    rel_index = a[ADDR_W-1:2] - BASE_IDX;
  endfunction

  // ports repeat every stride, so the port is the bits above the offset
  always_comb begin
    rel_idx  = rel_index(paddr_in);
    dec_port = rel_idx[OFF_W +: PI_W];
    dec_sub  = BASE_IDX + IDX_W'(rel_idx[OFF_W-1:0]);
    dec_hit  = (paddr_in[1:0] == 2'b00) &&
               (paddr_in[ADDR_W-1:2] >= BASE_IDX) &&
               (rel_idx < BLOCK_SPAN) &&
               (dec_sub >= IDX_MAINT) && (dec_sub <= IDX_IMP);
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rd_nxt = REG_RST;
    if (dec_hit) begin
      case (dec_sub)
        IDX_MAINT: rd_nxt = maint_r[dec_port];
        IDX_RT:    rd_nxt = rt_r[dec_port];
        IDX_MASK:  rd_nxt = mask_r[dec_port];
        IDX_LATCH: rd_nxt = flags[dec_port];
        IDX_LEVEL: rd_nxt = level_r[dec_port];
        IDX_IMP:   rd_nxt = imp_r[dec_port];
        default:   rd_nxt = REG_RST;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // apb handshake
  // ---------------------------------------------------------------
  // one wait-free access cycle; answers are prepared in setup so every bus output is a flop
  assign setup = psel_in && !penable_in;
  assign wr_en = psel_in && penable_in && pready_r && pwrite_in &&
                 acc_ok_r && pstrb_in[0];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      prdata_r   <= '0;
      acc_ok_r   <= 1'b0;
      acc_port_r <= '0;
      acc_sub_r  <= '0;
    end else if (setup) begin
      pready_r   <= 1'b1;
      pslverr_r  <= !dec_hit;
      prdata_r   <= (pwrite_in) ? '0 : DATA_W'(rd_nxt);
      acc_ok_r   <= dec_hit;
      acc_port_r <= dec_port;
      acc_sub_r  <= dec_sub;
    end else begin
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
    end
  end

  assign prdata_out  = prdata_r;
  assign pready_out  = pready_r;
  assign pslverr_out = pslverr_r;

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  // maintenance control, fully writable
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int p = 0; p < PORTS; p++) begin
        maint_r[p] <= REG_RST;
      end
    end else if (wr_en && acc_sub_r == IDX_MAINT) begin
      maint_r[acc_port_r] <= pwdata_in[REG_W-1:0];
    end
  end

  // interrupt mask
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int p = 0; p < PORTS; p++) begin
        mask_r[p] <= REG_RST;
      end
    end else if (wr_en && acc_sub_r == IDX_MASK) begin
      mask_r[acc_port_r] <= pwdata_in[REG_W-1:0];
    end
  end

  // receive impedance; unnamed bits stay zero
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int p = 0; p < PORTS; p++) begin
        imp_r[p] <= REG_RST;
      end
    end else if (wr_en && acc_sub_r == IDX_IMP) begin
      imp_r[acc_port_r] <= pwdata_in[REG_W-1:0] & IMP_WMASK;
    end
  end

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  // the level code may tear for one cycle while it changes; the next sample settles it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int p = 0; p < PORTS; p++) begin
        sy_a_r[p] <= '0;
        sy_b_r[p] <= '0;
      end
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        sy_a_r[p] <= raw[p];
        sy_b_r[p] <= sy_a_r[p];
      end
    end
  end

  // ---------------------------------------------------------------
  // per-port status and event logic
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < PORTS; g++) begin : g_port
      assign raw[g] = {transmit_enable_pin_in[g], short_haul_in[g], t1_mode_in[g],
                       pulse_shape_setting_in[g*3 +: 3],
                       receive_level_code_in[g*LEVEL_W +: LEVEL_W],
                       over_equalized_in[g], under_equalized_in[g],
                       receive_short_in[g], attenuator_trip_in[g],
                       transmit_open_in[g], transmit_short_in[g],
                       signal_loss_in[g]};

      // csu build-out shapes only exist in t1 mode
      assign csu_mode[g] = sy_b_r[g][SY_T1] &&
                           (sy_b_r[g][SY_SHAPE +: 3] >= CSU_SHAPE_MIN);

      // write-one-to-clear of the latched flags
      assign clear[g] = (wr_en && acc_sub_r == IDX_LATCH &&
                         acc_port_r == PI_W'(g)) ? pwdata_in[REG_W-1:0] : REG_RST;

      lums_flag_latch u_flags (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .cond_in     ({sy_b_r[g][SY_JA], sy_b_r[g][SY_OPEN],
                       sy_b_r[g][SY_TSHORT], sy_b_r[g][SY_LOS]}),
        .csu_mode_in (csu_mode[g]),
        .clear_in    (clear[g]),
        .flags_out   (flags[g])
      );

      assign irq_hit[g] = |(flags[g] & mask_r[g]);
    end
  endgenerate

  // real-time status copy
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int p = 0; p < PORTS; p++) begin
        rt_r[p] <= REG_RST;
      end
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        rt_r[p] <= REG_RST;
        rt_r[p][5] <= sy_b_r[p][SY_OEQ];
        rt_r[p][4] <= sy_b_r[p][SY_UEQ];
        rt_r[p][3] <= sy_b_r[p][SY_RSHORT];
        rt_r[p][2] <= sy_b_r[p][SY_TSHORT];
        rt_r[p][1] <= sy_b_r[p][SY_OPEN];
        rt_r[p][0] <= sy_b_r[p][SY_LOS];
      end
    end
  end

  // receive level, clamped to the gain limit on short-haul lines
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int p = 0; p < PORTS; p++) begin
        level_r[p] <= REG_RST;
      end
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        level_r[p] <= REG_RST;
        if (sy_b_r[p][SY_SHAUL] &&
            sy_b_r[p][SY_LVL +: LEVEL_W] > EQUALIZER_GAIN_LIMIT) begin
          level_r[p][LEVEL_LSB +: LEVEL_W] <= EQUALIZER_GAIN_LIMIT;
        end else begin
          level_r[p][LEVEL_LSB +: LEVEL_W] <= sy_b_r[p][SY_LVL +: LEVEL_W];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // line unit controls
  // ---------------------------------------------------------------
  // the driver needs both the enable pin and the register bit; power-down forces high-z over both
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      alarm_r    <= '0;
      lb_rem2_r  <= '0;
      lb_ana_r   <= '0;
      lb_rem1_r  <= '0;
      lb_loc_r   <= '0;
      tx_pd_r    <= '0;
      rx_pd_r    <= '0;
      tx_hiz_r   <= '1;
      term_on_r  <= '0;
      imp_code_r <= '0;
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        alarm_r[p] <= maint_r[p][MC_MANUAL_ALARM] ||
                      (maint_r[p][MC_AUTO_ALARM] && sy_b_r[p][SY_LOS]);
        lb_rem2_r[p] <= maint_r[p][MC_LB_LO +: LB_W] == LB_REMOTE2;
        lb_ana_r[p]  <= maint_r[p][MC_LB_LO +: LB_W] == LB_ANALOG;
        lb_rem1_r[p] <= maint_r[p][MC_LB_LO +: LB_W] == LB_REMOTE1 ||
                        maint_r[p][MC_LB_LO +: LB_W] == LB_DUAL;
        lb_loc_r[p]  <= maint_r[p][MC_LB_LO +: LB_W] == LB_LOCAL ||
                        maint_r[p][MC_LB_LO +: LB_W] == LB_DUAL;
        tx_pd_r[p] <= maint_r[p][MC_TX_PD];
        rx_pd_r[p] <= maint_r[p][MC_RX_PD];
        tx_hiz_r[p] <= maint_r[p][MC_TX_PD] ||
                       !maint_r[p][MC_TX_EN] || !sy_b_r[p][SY_TXEN];
        term_on_r[p] <= imp_r[p][IMP_TERM_ON];
        imp_code_r[p*IMP_CODE_W +: IMP_CODE_W] <= imp_r[p][IMP_CODE_W-1:0];
      end
    end
  end

  // one request line for all ports
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |irq_hit;
    end
  end

  assign alarm_send_out             = alarm_r;
  assign loop_remote2_out           = lb_rem2_r;
  assign loop_analog_out            = lb_ana_r;
  assign loop_remote1_out           = lb_rem1_r;
  assign loop_local_out             = lb_loc_r;
  assign transmit_power_down_out    = tx_pd_r;
  assign receive_power_down_out     = rx_pd_r;
  assign transmit_hiz_out           = tx_hiz_r;
  assign receive_termination_on_out = term_on_r;
  assign receive_impedance_code_out = imp_code_r;
  assign line_irq_out               = irq_r;

endmodule // lums_top
`default_nettype wire

// ==== src/lums_pkg.sv ====
// lums_pkg: constants for the line unit maintenance and status bank
// assumes: eight ports, register index = byte address / 4 on a 32-bit apb
package lums_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int             LUMS_PORTS  = 8;
  localparam int             PORT_W      = 3;
  localparam int             OFF_W       = 5;
  localparam int             ADDR_W      = 16;
  localparam int             IDX_W       = ADDR_W - 2;
  localparam int             DATA_W      = 32;
  localparam int             REG_W       = 8;

  // ---------------------------------------------------------------
  // register indices of port 1 (byte address is four times these)
  // ---------------------------------------------------------------
  localparam logic [IDX_W-1:0] BASE_IDX    = 14'h1000;
  localparam logic [IDX_W-1:0] PORT_STRIDE = 14'h0020;
  localparam logic [IDX_W-1:0] IDX_MAINT   = 14'h1002;
  localparam logic [IDX_W-1:0] IDX_RT      = 14'h1003;
  localparam logic [IDX_W-1:0] IDX_MASK    = 14'h1004;
  localparam logic [IDX_W-1:0] IDX_LATCH   = 14'h1005;
  localparam logic [IDX_W-1:0] IDX_LEVEL   = 14'h1006;
  localparam logic [IDX_W-1:0] IDX_IMP     = 14'h1007;
  localparam logic [IDX_W-1:0] BLOCK_SPAN  = 14'h0100;

  // ---------------------------------------------------------------
  // reset values and write masks
  // ---------------------------------------------------------------
  localparam logic [REG_W-1:0] REG_RST     = 8'h00;
  localparam logic [REG_W-1:0] IMP_WMASK   = 8'h47;

  // ---------------------------------------------------------------
  // maintenance control and receive impedance fields
  // ---------------------------------------------------------------
  localparam int MC_MANUAL_ALARM = 7;
  localparam int MC_AUTO_ALARM   = 6;
  localparam int MC_LB_LO        = 3;
  localparam int LB_W            = 3;
  localparam int MC_TX_PD        = 2;
  localparam int MC_RX_PD        = 1;
  localparam int MC_TX_EN        = 0;
  localparam int IMP_TERM_ON     = 6;
  localparam int IMP_CODE_W      = 3;

  // loopback select codes; 3'h6 and 3'h7 are reserved and act as none
  localparam logic [LB_W-1:0] LB_NONE    = 3'h0;
  localparam logic [LB_W-1:0] LB_REMOTE2 = 3'h1;
  localparam logic [LB_W-1:0] LB_ANALOG  = 3'h2;
  localparam logic [LB_W-1:0] LB_REMOTE1 = 3'h3;
  localparam logic [LB_W-1:0] LB_LOCAL   = 3'h4;
  localparam logic [LB_W-1:0] LB_DUAL    = 3'h5;

  // ---------------------------------------------------------------
  // event conditions, latched flags, level field
  // ---------------------------------------------------------------
  localparam int EVT_N      = 4;
  localparam int EVT_LOS    = 0;
  localparam int EVT_SHORT  = 1;
  localparam int EVT_OPEN   = 2;
  localparam int EVT_JA     = 3;
  localparam int LEVEL_LSB  = 4;
  localparam int LEVEL_W    = 4;
  localparam logic [2:0] CSU_SHAPE_MIN = 3'h5;

  // ---------------------------------------------------------------
  // positions in the synchronised per-port input vector
  // ---------------------------------------------------------------
  localparam int SY_LOS    = 0;
  localparam int SY_TSHORT = 1;
  localparam int SY_OPEN   = 2;
  localparam int SY_JA     = 3;
  localparam int SY_RSHORT = 4;
  localparam int SY_UEQ    = 5;
  localparam int SY_OEQ    = 6;
  localparam int SY_LVL    = 7;
  localparam int SY_SHAPE  = 11;
  localparam int SY_T1     = 14;
  localparam int SY_SHAUL  = 15;
  localparam int SY_TXEN   = 16;
  localparam int SY_W      = 17;

endpackage

// ==== src/lums_flag_latch.sv ====
// lums_flag_latch: sticky set/clear event flags of one port
// assumes: conditions already synchronised to clk_in; clear is a one-cycle mask
`timescale 1ns/1ps
`default_nettype none
module lums_flag_latch
  import lums_pkg::*;
(
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // conditions and mode
  input  wire logic [EVT_N-1:0] cond_in,
  input  wire logic             csu_mode_in,
  // software clear, one bit per flag
  input  wire logic [REG_W-1:0] clear_in,
  // latched flags
  output logic      [REG_W-1:0] flags_out
);

  logic [EVT_N-1:0] cond_d_r;
  logic [EVT_N-1:0] rise;
  logic [EVT_N-1:0] fall;
  logic [REG_W-1:0] flags_r;
  logic [REG_W-1:0] flags_nxt;

  // ---------------------------------------------------------------
  // edge detection
  // ---------------------------------------------------------------
  // conditions start as absent, so one present at release counts as detected
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cond_d_r <= '0;
    end else begin
      cond_d_r <= cond_in;
    end
  end

  // open and short rise detect are dead in the csu build-out shapes; their fall events still latch
  always_comb begin
    rise = cond_in & ~cond_d_r;
    rise[EVT_OPEN] = rise[EVT_OPEN] & ~csu_mode_in;
    rise[EVT_SHORT] = rise[EVT_SHORT] & ~csu_mode_in;
    fall = ~cond_in & cond_d_r;
  end

  // ---------------------------------------------------------------
  // sticky flags
  // ---------------------------------------------------------------
  // a new event beats a clear in the same cycle so nothing is lost
  assign flags_nxt = (flags_r & ~clear_in) | {fall, rise};

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags_r <= REG_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags_out = flags_r;

endmodule // lums_flag_latch
`default_nettype wire

// ==== verification/lums_monitor.sv ====
// lums_monitor: apb and line-control checks on lums_top ports
// assumes: bound into lums_top; one bit per port on line vectors
`timescale 1ns/1ps
`default_nettype none
module lums_monitor #(
  parameter int PORTS = 8
)(
  // clock, reset, apb
  input wire logic             clk_in,
  input wire logic             rst_in,
  input wire logic             psel_in,
  input wire logic             penable_in,
  input wire logic [15:0]      paddr_in,
  input wire logic [31:0]      prdata_out,
  input wire logic             pready_out,
  input wire logic             pslverr_out,
  // line controls
  input wire logic [PORTS-1:0] transmit_enable_pin_in,
  input wire logic [PORTS-1:0] loop_remote2_out,
  input wire logic [PORTS-1:0] loop_analog_out,
  input wire logic [PORTS-1:0] loop_remote1_out,
  input wire logic [PORTS-1:0] loop_local_out,
  input wire logic [PORTS-1:0] transmit_power_down_out,
  input wire logic [PORTS-1:0] transmit_hiz_out
);
  // eight copies of six registers; every other word must be refused
  wire logic mapped = paddr_in[15:10] == 6'h10 && paddr_in[6:2] >= 5'h02
                      && paddr_in[6:2] <= 5'h07 && paddr_in[1:0] == 2'h0;
  // local may only pair with remote 1, nothing else overlaps
  wire logic [PORTS-1:0] clash = loop_remote2_out & (loop_analog_out | loop_remote1_out
    | loop_local_out) | loop_analog_out & (loop_remote1_out | loop_local_out);
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (rst_in);
  AST_READY_SETUP: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready after setup");
  AST_READY_PULSE: assert property (pready_out |=> !pready_out)
    else $error("ready held");
  AST_DECODE: assert property (pready_out |-> pslverr_out == !mapped)
    else $error("bad error flag");
  AST_ERR_ZERO: assert property (pslverr_out |-> prdata_out == 32'h0)
    else $error("refused read has data");
  AST_UPPER_ZERO: assert property (pready_out |-> prdata_out[31:8] == 24'h0)
    else $error("upper bits set");
  AST_LOOP: assert property (clash == '0)
    else $error("loopback clash");
  AST_TXPD_HIZ: assert property ((transmit_power_down_out & ~transmit_hiz_out) == '0)
    else $error("powered-down driver on");
  AST_PIN_HIZ: assert property (
    (~$past(transmit_enable_pin_in, 3) & ~transmit_hiz_out) == '0)
    else $error("pin low, driver on");
endmodule // lums_monitor
bind lums_top lums_monitor #(.PORTS(PORTS)) u_lums_monitor (.clk_in, .rst_in, .psel_in,
  .penable_in, .paddr_in, .prdata_out, .pready_out, .pslverr_out, .transmit_enable_pin_in,
  .loop_remote2_out, .loop_analog_out, .loop_remote1_out, .loop_local_out,
  .transmit_power_down_out, .transmit_hiz_out);
`default_nettype wire

// ==== verification/lums_line_model.sv ====
// lums_line_model: far-side line, turns bench requests into monitor levels
// assumes: requests change just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module lums_line_model #(
  parameter int PORTS = 8
)(
  // requests and transmitter state
  input  wire logic [PORTS-1:0] los_req_in,
  input  wire logic [PORTS-1:0] fault_req_in,
  input  wire logic [PORTS-1:0] hiz_in,
  // conditions seen by the device
  output logic      [PORTS-1:0] signal_loss_out,
  output logic      [PORTS-1:0] transmit_open_out,
  output logic      [PORTS-1:0] transmit_short_out
);
  // a pair fault is only measurable while the driver is on
  assign signal_loss_out    = los_req_in;
  assign transmit_open_out  = fault_req_in & ~hiz_in;
  assign transmit_short_out = fault_req_in & ~hiz_in;
endmodule // lums_line_model
`default_nettype wire

// ==== verification/lums_top_bench.sv ====
// lums_top_bench: register and line checks of lums_top over apb
// assumes: lums_line_model on the line side, 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module lums_top_bench;
  // ----
  // signals
  // ----
  logic        clk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0, rd_err;
  logic [15:0] paddr_in = 0;
  logic [31:0] pwdata_in = 0, prdata_out, rd_data, receive_level_code_in = 0;
  logic [23:0] pulse_shape_setting_in = 0, receive_impedance_code_out;
  logic [7:0]  los_req = 0, fault = 0, t1_mode_in = 0, short_haul_in = 0,
               transmit_enable_pin_in = 8'hff, signal_loss_in, transmit_short_in,
               transmit_open_in, alarm_send_out, loop_remote2_out, loop_analog_out,
               loop_remote1_out, loop_local_out, transmit_power_down_out,
               receive_power_down_out, transmit_hiz_out, receive_termination_on_out;
  logic        pready_out, pslverr_out, line_irq_out;
  int          err_total = 0, n_checks = 0;
  logic [3:0]  lb_exp [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hc, 4'h0, 4'h0};
  wire logic [7:0] attenuator_trip_in = fault, receive_short_in = fault,
                   under_equalized_in = fault, over_equalized_in = fault;
  wire logic [3:0] lb_now = {loop_local_out[0], loop_remote1_out[0], loop_analog_out[0],
                             loop_remote2_out[0]};
  always #50 clk_in = ~clk_in;
  lums_top u_lums_top (.clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .pstrb_in(4'hf), .prdata_out, .pready_out, .pslverr_out, .signal_loss_in,
    .transmit_short_in, .transmit_open_in, .attenuator_trip_in, .receive_short_in,
    .under_equalized_in, .over_equalized_in, .receive_level_code_in,
    .pulse_shape_setting_in, .t1_mode_in, .short_haul_in, .transmit_enable_pin_in,
    .alarm_send_out, .loop_remote2_out, .loop_analog_out, .loop_remote1_out,
    .loop_local_out, .transmit_power_down_out, .receive_power_down_out, .transmit_hiz_out,
    .receive_termination_on_out, .receive_impedance_code_out, .line_irq_out);
  lums_line_model u_lums_line_model (.los_req_in(los_req), .fault_req_in(fault),
    .hiz_in(transmit_hiz_out), .signal_loss_out(signal_loss_in),
    .transmit_open_out(transmit_open_in), .transmit_short_out(transmit_short_in));
  // byte address of register r in the copy of port n
  function automatic logic [15:0] ad(input int n, input int r);
    return 16'((32'h1000 + 32'h20 * (n - 1) + r) * 4);
  endfunction
  task automatic tick(input int c);
    repeat (c) @(posedge clk_in);
  endtask
  // one apb transfer, request held until ready is seen at an edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
    psel_in <= 1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= {24'h0, d};
    @(posedge clk_in);
    penable_in <= 1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd_data = prdata_out;
    rd_err = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
    tick(2);
  endtask
  task automatic wr(input int n, input int r, input logic [7:0] d);
    apb(1, ad(n, r), d);
  endtask
  task automatic rd(input int n, input int r, input logic [7:0] e);
    apb(0, ad(n, r), 8'h0);
    `CHK(rd_data, {24'h0, e})
  endtask
  task automatic finish_test();
    if (err_total == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    tick(2);
    rst_in <= 0;
    tick(1);
    `CHK(transmit_hiz_out, 8'hff)
    for (int r = 2; r < 8; r++) rd(1, r, 8'h00);
    wr(8, 4, 8'ha5);
    rd(8, 4, 8'ha5);
    rd(1, 4, 8'h00);
    wr(1, 3, 8'hff);
    rd(1, 3, 8'h00);
    rd(1, 8, 8'h00);
    `CHK(rd_err, 1'b1)
    wr(1, 7, 8'hff);
    rd(1, 7, 8'h47);
    `CHK({receive_termination_on_out[0], receive_impedance_code_out[2:0]}, 4'hf)
    for (int c = 0; c < 8; c++) begin
      wr(1, 2, 8'(c << 3));
      `CHK(lb_now, lb_exp[c])
    end
    wr(1, 2, 8'h01);
    `CHK(transmit_hiz_out[0], 1'b0)
    transmit_enable_pin_in[0] <= 0;
    tick(4);
    `CHK(transmit_hiz_out[0], 1'b1)
    transmit_enable_pin_in[0] <= 1;
    wr(1, 2, 8'h87);
    `CHK({alarm_send_out[0], transmit_power_down_out[0], receive_power_down_out[0]}, 3'h7)
    wr(1, 2, 8'h41);
    wr(1, 4, 8'h11);
    los_req[0] <= 1;
    fault[0] <= 1;
    tick(5);
    `CHK(alarm_send_out[0], 1'b1)
    rd(1, 3, 8'h3f);
    rd(1, 5, 8'h0f);
    `CHK(line_irq_out, 1'b1)
    los_req[0] <= 0;
    fault[0] <= 0;
    tick(5);
    rd(1, 5, 8'hff);
    wr(1, 5, 8'h01);
    rd(1, 5, 8'hfe);
    `CHK(line_irq_out, 1'b1)
    wr(1, 5, 8'hff);
    tick(2);
    `CHK(line_irq_out, 1'b0)
    t1_mode_in[0] <= 1;
    pulse_shape_setting_in[2:0] <= 3'h5;
    tick(4);
    fault[0] <= 1;
    tick(5);
    rd(1, 5, 8'h08);
    receive_level_code_in[3:0] <= 4'h9;
    tick(4);
    rd(1, 6, 8'h90);
    short_haul_in[0] <= 1;
    receive_level_code_in[3:0] <= 4'hf;
    tick(4);
    rd(1, 6, 8'hc0);
    finish_test();
  end
  // watchdog, far beyond the fewer than two hundred cycles the tests need
  initial begin
    tick(5000);
    err_total++;
    finish_test();
  end
endmodule // lums_top_bench
`default_nettype wire
